// ===== rtl/dme_addr_if.sv
// carrier between the move executor and its file-address resolver
// assumes both ends on core_clk; pure combinational path
interface dme_addr_if;
  logic [7:0] file_operand;
  logic access_bit;
  logic [7:0] bank_select;
  logic ext_set_en;
  logic [11:0] index_base;
  logic [11:0] full_addr;

  modport exec (
    output file_operand, access_bit, bank_select, ext_set_en, index_base,
    input full_addr
  );
  modport resolver (
    input file_operand, access_bit, bank_select, ext_set_en, index_base,
    output full_addr
  );
endinterface : dme_addr_if

// ===== rtl/dme_addr_resolve.sv
// resolver of an 8-bit banked file operand into a 12-bit data address
// assumes index_base holds the indexing pointer for literal offset mode
module dme_addr_resolve (
  dme_addr_if.resolver bus
);

  wire use_indexed = bus.ext_set_en && (bus.file_operand <= dme_pkg::INDEXED_LIMIT);
  wire low_access = bus.file_operand < dme_pkg::ACCESS_SPLIT;
  wire [11:0] indexed_addr = bus.index_base + {4'h0, bus.file_operand};
  wire [11:0] access_addr = low_access ? {dme_pkg::ACCESS_LOW_PAGE, bus.file_operand}
                                       : {dme_pkg::ACCESS_HIGH_PAGE, bus.file_operand};
  wire [11:0] banked_addr = {bus.bank_select[3:0], bus.file_operand};   // [RL14] [RL16]
  wire [11:0] unbanked_addr = use_indexed ? indexed_addr          // [RL17]
                                          : access_addr;          // [RL18]

  assign bus.full_addr = bus.access_bit ? banked_addr : unbanked_addr;   // [RL15]

endmodule : dme_addr_resolve

// ===== rtl/dme_move_exec.sv
// execution unit for the core's data-move instructions, one q phase per clock
// assumes a combinational data memory read and a same-clock instruction source
// Operation
// RL1 - move file: d=0 to work, d=1 back
// RL2 - move file sets negative and zero only
// RL3 - one-word moves: one cycle, four q phases
// RL4 - file-to-file copies source, no flags touched
// RL5 - source from 1100 word, dest from 1111
// RL6 - both addresses span full 4096-byte space
// RL7 - work register addressable as source or destination
// RL8 - program must not target counter or stack
// RL9 - two words, read first q2, write second q4
// RL10 - bank literal loads bank select in q4
// RL11 - bank select upper nibble always reads zero
// RL12 - work literal loads work in q4
// RL13 - store work to file, flags untouched
// RL14 - file operand spans 256-byte bank
// RL15 - access bit 0 selects access bank
// RL16 - access bit 1 uses bank select
// RL17 - extended set, offset 5fh or below indexes
// RL18 - otherwise plain access bank addressing
module dme_move_exec #(
  parameter logic [11:0] WORK_ADDR = dme_pkg::WORK_ADDR_DEF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] instr_word,
  input wire logic ext_set_en,
  input wire logic [11:0] index_base,
  input wire logic [7:0] mem_rd_data,
  output logic instr_taken,
  output logic [1:0] q_phase,
  output logic [11:0] mem_addr,
  output logic mem_rd_en,
  output logic mem_wr_en,
  output logic [7:0] mem_wr_data,
  output logic [7:0] work_reg,
  output logic [7:0] bank_select_reg,
  output logic flag_neg,
  output logic flag_zero
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dme_pkg::dme_q_type q_ff;
  dme_pkg::dme_q_type nxt_q;
  logic [15:0] ir_ff;
  logic second_ff;
  logic taken_ff;
  logic [11:0] addr_ff;
  logic rd_ff;
  logic wr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] data_ff;
  logic [7:0] work_ff;
  logic [7:0] bank_sel_ff;
  logic neg_ff;
  logic zero_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // incoming word at the q1 edge so the read can launch into q2, held word after
  wire [15:0] dec_word = (q_ff == dme_pkg::DME_Q1) ? instr_word : ir_ff;
  wire is_move_file = !second_ff && dec_word[15:10] == dme_pkg::OPC_MOVE_FILE_TO_DEST;
  wire is_ff_src = !second_ff && dec_word[15:12] == dme_pkg::OPC_FILE_TO_FILE_SRC;   // [RL5]
  wire is_ff_dst = second_ff && dec_word[15:12] == dme_pkg::OPC_FILE_TO_FILE_DST;    // [RL5]
  wire is_bank_lit = !second_ff && dec_word[15:8] == dme_pkg::OPC_LOAD_BANK_SELECT;
  wire is_work_lit = !second_ff && dec_word[15:8] == dme_pkg::OPC_LOAD_WORK_LITERAL;
  wire is_store_work = !second_ff && dec_word[15:9] == dme_pkg::OPC_STORE_WORK_TO_FILE;
  wire dest_file = dec_word[dme_pkg::DEST_BIT];
  wire reads_file = is_move_file || is_ff_src;

  // ----------------------------------------------------------------
  // address resolution
  // ----------------------------------------------------------------
  dme_addr_if addr_bus ();
  assign addr_bus.file_operand = dec_word[7:0];
  assign addr_bus.access_bit = dec_word[dme_pkg::ACCESS_BIT];
  assign addr_bus.bank_select = bank_sel_ff;
  assign addr_bus.ext_set_en = ext_set_en;
  assign addr_bus.index_base = index_base;

  dme_addr_resolve u_resolve (
    .bus(addr_bus)
  );

  // full 12-bit operand, no banking, for the two-word move
  wire [11:0] rd_addr = is_ff_src ? dec_word[11:0] : addr_bus.full_addr;   // [RL6]
  wire [11:0] wr_addr = is_ff_dst ? dec_word[11:0] : addr_bus.full_addr;   // [RL6]
  // work register answers at its own address
  wire [7:0] rd_value = (addr_ff == WORK_ADDR) ? work_ff : mem_rd_data;  // [RL7]
  wire wr_work_hit = wr_addr == WORK_ADDR;                               // [RL7]
  wire [7:0] wr_value = is_store_work ? work_ff : (is_ff_dst ? data_ff : rd_value);
  wire do_mem_wr = (is_store_work || is_ff_dst || (is_move_file && dest_file)) && !wr_work_hit;

  // ----------------------------------------------------------------
  // q phase sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (q_ff)
      dme_pkg::DME_Q1: nxt_q = dme_pkg::DME_Q2;
      dme_pkg::DME_Q2: nxt_q = dme_pkg::DME_Q3;
      dme_pkg::DME_Q3: nxt_q = dme_pkg::DME_Q4;
      dme_pkg::DME_Q4: nxt_q = dme_pkg::DME_Q1;
      default: nxt_q = dme_pkg::DME_Q1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= dme_pkg::DME_Q1;
    end else begin
      q_ff <= nxt_q;   // [RL3]
    end
  end

  // ----------------------------------------------------------------
  // fetch and decode (q1)
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_ff <= dme_pkg::WORD_RESET;
      taken_ff <= 1'b0;
      second_ff <= 1'b0;
    end else begin
      taken_ff <= q_ff == dme_pkg::DME_Q1;
      if (q_ff == dme_pkg::DME_Q1) begin
        ir_ff <= instr_word;
      end
      if (q_ff == dme_pkg::DME_Q4) begin
        second_ff <= is_ff_src;   // [RL9]
      end
    end
  end

  // ----------------------------------------------------------------
  // memory port: read in q2, write in q4
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= dme_pkg::ADDR_RESET;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      wdata_ff <= dme_pkg::BYTE_RESET;
      data_ff <= dme_pkg::BYTE_RESET;
    end else begin
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
      if (q_ff == dme_pkg::DME_Q1 && reads_file) begin
        addr_ff <= rd_addr;
      end
      if (q_ff == dme_pkg::DME_Q1) begin
        rd_ff <= reads_file;   // [RL9]
      end
      if (q_ff == dme_pkg::DME_Q2 && reads_file) begin
        data_ff <= rd_value;   // [RL4]
      end
      if (q_ff == dme_pkg::DME_Q3 && do_mem_wr) begin
        addr_ff <= wr_addr;
        wr_ff <= 1'b1;           // [RL13] [RL9]
        wdata_ff <= wr_value;    // [RL1] [RL4]
      end
    end
  end

  // ----------------------------------------------------------------
  // core registers and flags, committed at end of q4
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_ff <= dme_pkg::BYTE_RESET;
      bank_sel_ff <= dme_pkg::BYTE_RESET;
      neg_ff <= 1'b0;
      zero_ff <= 1'b0;
    end else if (q_ff == dme_pkg::DME_Q4) begin
      if (is_work_lit) begin
        work_ff <= ir_ff[7:0];   // [RL12]
      end else if (is_move_file && !dest_file) begin
        work_ff <= data_ff;      // [RL1]
      end else if ((is_move_file || is_ff_dst) && wr_work_hit) begin
        work_ff <= data_ff;      // [RL7]
      end
      if (is_bank_lit) begin
        bank_sel_ff <= ir_ff[7:0] & dme_pkg::BANK_SELECT_MASK;   // [RL10] [RL11]
      end
      if (is_move_file) begin
        neg_ff <= data_ff[7];              // [RL2]
        zero_ff <= data_ff == 8'h00;       // [RL2]
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign instr_taken = taken_ff;
  assign q_phase = q_ff;
  assign mem_addr = addr_ff;
  assign mem_rd_en = rd_ff;
  assign mem_wr_en = wr_ff;
  assign mem_wr_data = wdata_ff;
  assign work_reg = work_ff;
  assign bank_select_reg = bank_sel_ff;
  assign flag_neg = neg_ff;
  assign flag_zero = zero_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dme_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_q_phase_order: assert property ( // [RL3]
    q_ff == dme_pkg::DME_Q1 |=> q_ff == dme_pkg::DME_Q2 ##1 q_ff == dme_pkg::DME_Q3
      ##1 q_ff == dme_pkg::DME_Q4 ##1 q_ff == dme_pkg::DME_Q1)
    else $error("q phases out of order");

  chk_move_to_work: assert property ( // [RL1]
    q_ff == dme_pkg::DME_Q4 && is_move_file && !dest_file |=> work_ff == $past(data_ff))
    else $error("move file to work lost value");

  chk_move_flags: assert property ( // [RL2]
    q_ff == dme_pkg::DME_Q4 && is_move_file
      |=> neg_ff == $past(data_ff[7]) && zero_ff == ($past(data_ff) == 8'h00))
    else $error("move file flags wrong");

  chk_read_in_q2: assert property ( // [RL3]
    rd_ff |-> q_ff == dme_pkg::DME_Q2)
    else $error("file read outside q2");

  chk_f2f_src_read: assert property ( // [RL6]
    q_ff == dme_pkg::DME_Q1 && is_ff_src |=> rd_ff && addr_ff == $past(instr_word[11:0]))
    else $error("file to file source read wrong");

  chk_f2f_no_flags: assert property ( // [RL4]
    q_ff == dme_pkg::DME_Q1 && second_ff |=> ($stable(neg_ff) && $stable(zero_ff)) [*4])
    else $error("file to file touched flags");

  chk_f2f_dest_write: assert property ( // [RL9]
    q_ff == dme_pkg::DME_Q3 && is_ff_dst && !wr_work_hit
      |=> wr_ff && addr_ff == $past(ir_ff[11:0]) && wdata_ff == $past(data_ff))
    else $error("file to file write missing");

  chk_f2f_no_dummy: assert property ( // [RL9]
    second_ff |-> !rd_ff)
    else $error("dummy read in second word");

  chk_bank_load: assert property ( // [RL10]
    q_ff == dme_pkg::DME_Q4 && is_bank_lit |=> bank_sel_ff == {4'h0, $past(ir_ff[3:0])})
    else $error("bank select load wrong");

  chk_bank_upper_zero: assert property ( // [RL11]
    bank_sel_ff[7:4] == 4'h0)
    else $error("bank select upper nibble set");

  chk_work_literal: assert property ( // [RL12]
    q_ff == dme_pkg::DME_Q4 && is_work_lit |=> work_ff == $past(ir_ff[7:0]) && $stable(zero_ff))
    else $error("work literal load wrong");

  chk_store_work: assert property ( // [RL13]
    q_ff == dme_pkg::DME_Q3 && is_store_work && !wr_work_hit
      |=> wr_ff && wdata_ff == work_ff ##1 $stable(neg_ff))
    else $error("store work to file wrong");

endmodule : dme_move_exec

// ===== rtl/dme_pkg.sv
// package for the data-move execution block: opcodes, masks, addresses, phases
// assumes one core clock, one q phase per core clock edge
package dme_pkg;

  // ----------------------------------------------------------------
  // q phases of one instruction cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DME_Q1 = 2'b00,
    DME_Q2 = 2'b01,
    DME_Q3 = 2'b10,
    DME_Q4 = 2'b11
  } dme_q_type;

  // ----------------------------------------------------------------
  // opcode fields
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_MOVE_FILE_TO_DEST = 6'h14;
  localparam logic [3:0] OPC_FILE_TO_FILE_SRC = 4'hc;
  localparam logic [3:0] OPC_FILE_TO_FILE_DST = 4'hf;
  localparam logic [7:0] OPC_LOAD_BANK_SELECT = 8'h01;
  localparam logic [7:0] OPC_LOAD_WORK_LITERAL = 8'h0e;
  localparam logic [6:0] OPC_STORE_WORK_TO_FILE = 7'h37;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;

  // ----------------------------------------------------------------
  // addressing constants and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] WORK_ADDR_DEF = 12'hfe0;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;
  localparam logic [7:0] BANK_SELECT_MASK = 8'h0f;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [11:0] ADDR_RESET = 12'h000;

endpackage : dme_pkg

// ===== verification/data_move_instruction_exec_tb_top.sv
// self-checking bench for the data-move executor
// assumes a combinational data memory modelled here and core_clk at 4 ns
module data_move_instruction_exec_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // stimulus, memory model and design
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic ext_set_en = 1'b0;
  logic [11:0] index_base = 12'h200;
  logic [7:0] mem_rd_data;
  logic instr_taken, mem_rd_en, mem_wr_en, flag_neg, flag_zero;
  logic [1:0] q_phase;
  logic [11:0] mem_addr, rd_addr, wr_addr;
  logic [7:0] mem_wr_data, work_reg, bank_select_reg, wr_data, rd_cnt, wr_cnt;
  logic [7:0] mem [4096];
  logic fn, fz;
  int bad_count = 0;
  int check_count = 0;

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  assign mem_rd_data = mem[mem_addr];

  always @(posedge core_clk) begin
    if (mem_wr_en === 1'b1) begin
      mem[mem_addr] <= mem_wr_data;
    end
  end

  dme_move_exec u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .instr_word(instr_word),
    .ext_set_en(ext_set_en), .index_base(index_base), .mem_rd_data(mem_rd_data),
    .instr_taken(instr_taken), .q_phase(q_phase), .mem_addr(mem_addr),
    .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
    .work_reg(work_reg), .bank_select_reg(bank_select_reg),
    .flag_neg(flag_neg), .flag_zero(flag_zero)
  );

  // ----------------------------------------------------------------
  // compare and drive helpers
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: address got %h expected %h", $time, got, exp);
    end
  endtask : chk_addr

  task automatic chk_flags();
    chk_byte({6'h00, flag_neg, flag_zero}, {6'h00, fn, fz});
  endtask : chk_flags

  task automatic clr();
    rd_cnt = 8'h00;
    wr_cnt = 8'h00;
    fn = flag_neg;
    fz = flag_zero;
  endtask : clr

  // one instruction word per four q phases, sampled at falling edges
  task automatic exec(input logic [15:0] word);
    int n;
    n = 0;
    while (q_phase !== 2'h0 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    instr_word = word;
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      if (i == 0) begin
        chk_byte({7'h00, instr_taken}, 8'h01);
      end
      if (mem_rd_en === 1'b1) begin
        rd_cnt++;
        rd_addr = mem_addr;
        chk_byte({6'h00, q_phase}, 8'h01);
      end
      if (mem_wr_en === 1'b1) begin
        wr_cnt++;
        wr_addr = mem_addr;
        wr_data = mem_wr_data;
        chk_byte({6'h00, q_phase}, 8'h03);
      end
    end
  endtask : exec

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_move_file();
    exec(16'h0103);
    mem[12'h344] = 8'h80;
    clr();
    exec(16'h5144);
    chk_addr(rd_addr, 12'h344);
    chk_byte(wr_cnt, 8'h00);
    chk_byte(work_reg, 8'h80);
    chk_byte({6'h00, flag_neg, flag_zero}, 8'h02);
    mem[12'h3ff] = 8'h00;
    clr();
    exec(16'h53ff);
    chk_addr(wr_addr, 12'h3ff);
    chk_byte(wr_data, 8'h00);
    chk_byte(work_reg, 8'h80);
    chk_byte({6'h00, flag_neg, flag_zero}, 8'h01);
    $display("test move file done");
  endtask : t_move_file

  task automatic t_literals();
    clr();
    exec(16'h0e5a);
    chk_byte(work_reg, 8'h5a);
    exec(16'h01a5);
    chk_byte(bank_select_reg, 8'h05);
    chk_flags();
    $display("test literals done");
  endtask : t_literals

  task automatic one_store(input logic [15:0] w, input logic e, input logic [11:0] exp);
    ext_set_en = e;
    clr();
    exec(w);
    chk_byte(wr_cnt, 8'h01);
    chk_addr(wr_addr, exp);
    chk_byte(wr_data, 8'h4f);
    chk_flags();
  endtask : one_store

  task automatic t_access();
    exec(16'h0e4f);
    one_store(16'h6e10, 1'b0, 12'h010);
    one_store(16'h6e80, 1'b0, 12'hf80);
    one_store(16'h6e5f, 1'b1, 12'h25f);
    one_store(16'h6e60, 1'b1, 12'hf60);
    one_store(16'h6f22, 1'b1, 12'h522);
    ext_set_en = 1'b0;
    $display("test access done");
  endtask : t_access

  task automatic t_f2f();
    mem[12'h123] = 8'h33;
    mem[12'hfff] = 8'h5c;
    mem[12'hfe0] = 8'hee;
    clr();
    exec(16'hc123);
    chk_byte(wr_cnt, 8'h00);
    exec(16'hfabc);
    chk_byte(rd_cnt, 8'h01);
    chk_addr(rd_addr, 12'h123);
    chk_addr(wr_addr, 12'habc);
    chk_byte(wr_data, 8'h33);
    chk_byte(mem[12'h123], 8'h33);
    chk_flags();
    exec(16'hcfff);
    exec(16'hf000);
    chk_addr(wr_addr, 12'h000);
    chk_byte(wr_data, 8'h5c);
    exec(16'hc000);
    exec(16'hffe0);
    chk_byte(work_reg, 8'h5c);
    exec(16'h0e77);
    exec(16'hcfe0);
    exec(16'hf001);
    chk_byte(wr_data, 8'h77);
    clr();
    exec(16'hc123);
    exec(16'h0000);
    chk_byte(wr_cnt, 8'h00);
    $display("test file to file done");
  endtask : t_f2f

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'h00;
    end
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    t_move_file();
    t_literals();
    t_access();
    t_f2f();
    end_of_test();
  end

  // about 22 instructions of 4 cycles each; generous margin
  initial begin
    #8000;
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    end_of_test();
  end
endmodule : data_move_instruction_exec_tb_top
